// *** adc_link_defines.svh ***
// Timing counts and code points shared by both ends of the converter link.
// Assumes a 200 MHz core clock; included by the package, both design ends and the testbench.
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

`define CLK_PERIOD_PS        5000
`define MIN_RATE_SPS         1000000
`define WAKE_CYCLES          7
`define OE_SETTLE_CYCLES     5
`define DUTY_FIX_LO_PCT      30
`define DUTY_FIX_HI_PCT      70
`define DUTY_RAW_LO_PCT      48
`define DUTY_RAW_HI_PCT      52
`define CODE_TOP             10'h3ff
`define CODE_HALF_UP         10'h300
`define CODE_MID             10'h200
`define CODE_HALF_DOWN       10'h100
`define CODE_BOTTOM          10'h000
`define CODE_LSB_RANGE       10'h000

`endif

// *** adc_link_pkg.sv ***
// Types shared by both ends of the converter link.
// Assumes adc_link_defines.svh is on the include path.
`include "adc_link_defines.svh"

package adc_link_pkg;
    localparam int CHANNELS = 8;
    localparam int CODE_W   = 10;
    typedef logic [CODE_W-1:0] code_type;
    typedef enum logic {
        raw_clock,
        fixed_clock
    } duty_mode_type;
endpackage

// *** adc_link_if.sv ***
// Pin bundle between the converter end and the capture end.
// The testbench resolves the shared data bus from the enable.
`timescale 1ns/1ps

interface adc_link_if
    import adc_link_pkg::*;
    ();
    logic                                    duty_fix_select;
    logic                                    output_enable_n;
    logic [CHANNELS-1:0]                     channel_sleep_n;
    logic [CHANNELS-1:0][CODE_W-1:0]         data_out;
    logic                                    data_oe;
    logic [CHANNELS-1:0][CODE_W-1:0]         data_in;

    modport converter (
        input  duty_fix_select,
        input  output_enable_n,
        input  channel_sleep_n,
        output data_out,
        output data_oe
    );
    modport capture (
        output duty_fix_select,
        output output_enable_n,
        output channel_sleep_n,
        input  data_in
    );
endinterface // adc_link_if

// *** adc_converter.sv ***
// Converter end: digital pipeline and output stage of the eight channels.
// Pins arrive from the capture end; samples come in as positive/negative
// input words standing in for the analog front end.
`timescale 1ns/1ps
`include "adc_link_defines.svh"

// Function
// R01: Low select bypasses duty conditioning
// R02: High select enables duty conditioning
// R03: Pipeline uses both clock edges
// R04: Clock must stay above minimum rate
// R05: Offset binary, top bit is bit nine
// R06: Full scale and zero code points
// R07: Half scale code points
// R08: Enable low drives all buses
// R09: Enable high floats all buses together
// R10: Enable input always driven defined
// R11: Per channel sleep input, low powers down
// R12: Power down invalidates the pipeline
// R13: Valid data after seven wake cycles
// R14: Do not multiplex via sleep inputs
// R15: Clock valid during power up
// R16: All channels sampled together each cycle
module adc_converter
    import adc_link_pkg::*;
#(
    parameter int WAKE = `WAKE_CYCLES
) (
    input  wire logic                            core_clk_in,
    input  wire logic                            rst_n_in,
    adc_link_if.converter                        link,
    input  wire logic [CHANNELS-1:0][CODE_W-1:0] positive_input_in,
    input  wire logic [CHANNELS-1:0][CODE_W-1:0] negative_input_in,
    output logic                                 duty_fixed_out,
    output logic [CHANNELS-1:0]                  channel_valid_out
);
    // Elaboration checks: wake count is 8 bits, code points are 10 bits
    if (WAKE < 1 || WAKE > 255) begin : g_bad_wake
        $error("WAKE out of range");
    end
    if (CODE_W != 10) begin : g_bad_width
        $error("Code points need a 10-bit code");
    end
    if (CHANNELS < 1) begin : g_bad_chan
        $error("At least one channel needed");
    end

    // Pin inputs pass two flops first
    // Costs two cycles on every control pin, buys metastability margin
    logic                sel_s1, sel_s2, next_sel_s1, next_sel_s2;
    always_comb begin
        next_sel_s1 = link.duty_fix_select;
        next_sel_s2 = sel_s1;
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            sel_s1 <= next_sel_s1;
            sel_s2 <= next_sel_s2;
        end
    end

    logic                oe_n_s1, oe_n_s2, next_oe_n_s1, next_oe_n_s2;
    always_comb begin
        next_oe_n_s1 = link.output_enable_n;
        next_oe_n_s2 = oe_n_s1;
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            // Float the bus until a defined enable level arrives
            oe_n_s1 <= 1'b1;
            oe_n_s2 <= 1'b1;
        end else begin
            oe_n_s1 <= next_oe_n_s1;
            oe_n_s2 <= next_oe_n_s2;
        end
    end

    logic [CHANNELS-1:0] slp_s1, slp_s2, next_slp_s1, next_slp_s2;
    always_comb begin
        next_slp_s1 = link.channel_sleep_n;
        next_slp_s2 = slp_s1;
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            slp_s1 <= '0;
            slp_s2 <= '0;
        end else begin
            slp_s1 <= next_slp_s1;
            slp_s2 <= next_slp_s2;
        end
    end

    // R01 R02 duty mode flag
    duty_mode_type mode, next_mode;
    always_comb begin
        next_mode = sel_s2 ? fixed_clock : raw_clock;
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode <= raw_clock;
        end else begin
            mode <= next_mode;
        end
    end

    // R03 half-cycle stage on falling edge; a real pipeline splits work
    // across both phases, so the conversion is registered on negedge first
    logic [CHANNELS-1:0][CODE_W-1:0] half_stage;
    logic [CHANNELS-1:0][CODE_W-1:0] next_half_stage;
    logic [CHANNELS-1:0][CODE_W-1:0] code_stage, next_code_stage;
    logic [CHANNELS-1:0][7:0]        wake_cnt, next_wake_cnt;
    logic [CHANNELS-1:0]             valid, next_valid;
    logic [CHANNELS-1:0][CODE_W-1:0] bus, next_bus;
    logic                            oe, next_oe;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            logic [CODE_W:0] diff;
            // R05 R06 R07 offset binary: mid plus half the difference
            always_comb begin
                diff = {1'b0, positive_input_in[g]}
                     - {1'b0, negative_input_in[g]};
                next_half_stage[g] = diff[CODE_W:1] + `CODE_MID;
                if (!diff[CODE_W] && positive_input_in[g] == `CODE_TOP
                        && negative_input_in[g] == `CODE_BOTTOM) begin
                    next_half_stage[g] = `CODE_TOP;
                end else if (diff[CODE_W] && negative_input_in[g]
                        == `CODE_TOP && positive_input_in[g]
                        == `CODE_BOTTOM) begin
                    next_half_stage[g] = `CODE_BOTTOM;
                end
            end

            // Count stops at WAKE so a long wake never wraps
            // R11 R12 R13 wake count, cleared on sleep
            always_comb begin
                next_wake_cnt[g] = wake_cnt[g];
                next_valid[g]    = valid[g];
                if (!slp_s2[g]) begin
                    next_wake_cnt[g] = '0;
                    next_valid[g]    = 1'b0;
                end else if (wake_cnt[g] < WAKE[7:0]) begin
                    next_wake_cnt[g] = wake_cnt[g] + 8'h01;
                    next_valid[g]    = (wake_cnt[g] + 8'h01) >= WAKE[7:0];
                end
            end

            // R12 sleeping channel holds no stale code
            always_comb begin
                next_code_stage[g] = slp_s2[g] ? half_stage[g] : '0;
                next_bus[g]        = code_stage[g];
            end
        end
    endgenerate

    always_ff @(negedge core_clk_in) begin
        if (!rst_n_in) begin
            half_stage <= '0;
        end else begin
            half_stage <= next_half_stage;
        end
    end

    // R08 R09 shared enable for all buses
    always_comb begin
        next_oe = !oe_n_s2;
    end

    // R11 R13 wake count and valid flag
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wake_cnt <= '0;
            valid    <= '0;
        end else begin
            wake_cnt <= next_wake_cnt;
            valid    <= next_valid;
        end
    end

    // R16 all channels registered on one edge
    // A second stage keeps the pin straight off a flop at one cycle's cost
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            code_stage <= '0;
            bus        <= '0;
        end else begin
            code_stage <= next_code_stage;
            bus        <= next_bus;
        end
    end

    // R08 R09 one enable flop for all buses
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            oe <= 1'b0;
        end else begin
            oe <= next_oe;
        end
    end

    assign link.data_out     = bus;
    assign link.data_oe      = oe;
    assign duty_fixed_out    = (mode == fixed_clock);
    assign channel_valid_out = valid;
endmodule // adc_converter

// *** adc_capture.sv ***
// Capture end: drives the control pins and takes in the eight code buses.
// Data pins come from the converter's clock domain copy of core_clk_in.
`timescale 1ns/1ps
`include "adc_link_defines.svh"

module adc_capture
    import adc_link_pkg::*;
#(
    parameter int WAKE = `WAKE_CYCLES
) (
    input  wire logic                            core_clk_in,
    input  wire logic                            rst_n_in,
    adc_link_if.capture                          link,
    input  wire logic                            duty_fix_req_in,
    input  wire logic                            read_req_in,
    input  wire logic [CHANNELS-1:0]             channel_on_in,
    output logic [CHANNELS-1:0][CODE_W-1:0]      sample_out,
    output logic [CHANNELS-1:0]                  sample_valid_out
);
    // Guard count must fit the 8-bit age counter
    if (WAKE < 1 || WAKE > 249) begin : g_bad_wake
        $error("WAKE out of range");
    end

    logic                            sel, next_sel;
    logic                            oe_n, next_oe_n;
    logic [CHANNELS-1:0]             slp_n, next_slp_n;
    logic [CHANNELS-1:0][CODE_W-1:0] d_s1, d_s2, next_d_s1, next_d_s2;
    logic [CHANNELS-1:0][7:0]        age, next_age;
    logic [CHANNELS-1:0][CODE_W-1:0] smp, next_smp;
    logic [CHANNELS-1:0]             sv, next_sv;
    logic [2:0]                      en_age, next_en_age;

    // Margin covers converter sync, pipeline and our own pin sync
    localparam logic [7:0] GUARD = 8'(WAKE + 6);

    always_comb begin
        next_sel   = duty_fix_req_in;
        // R10 enable always at a defined level
        next_oe_n  = !read_req_in;
        // R14 sleep pins follow static channel use
        next_slp_n = channel_on_in;
        next_d_s1  = link.data_in;
        next_d_s2  = d_s1;
        // R08 R09 bus floats until the far enable path settles
        next_en_age = en_age;
        if (oe_n) begin
            next_en_age = '0;
        end else if (en_age < 3'(`OE_SETTLE_CYCLES)) begin
            next_en_age = en_age + 3'h1;
        end
        for (int c = 0; c < CHANNELS; c++) begin
            next_age[c] = age[c];
            // R13 discard samples before wake guard
            if (!slp_n[c]) begin
                next_age[c] = '0;
            end else if (age[c] < GUARD) begin
                next_age[c] = age[c] + 8'h01;
            end
            next_sv[c]  = slp_n[c] && !oe_n && (age[c] >= GUARD)
                        && (en_age >= 3'(`OE_SETTLE_CYCLES));
            next_smp[c] = next_sv[c] ? d_s2[c] : smp[c];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sel   <= 1'b0;
            oe_n  <= 1'b1;
            slp_n <= '0;
            d_s1  <= '0;
            d_s2  <= '0;
            age   <= '0;
            smp   <= '0;
            sv    <= '0;
            en_age <= '0;
        end else begin
            sel   <= next_sel;
            oe_n  <= next_oe_n;
            slp_n <= next_slp_n;
            d_s1  <= next_d_s1;
            d_s2  <= next_d_s2;
            age   <= next_age;
            smp   <= next_smp;
            sv    <= next_sv;
            en_age <= next_en_age;
        end
    end

    assign link.duty_fix_select = sel;
    assign link.output_enable_n = oe_n;
    assign link.channel_sleep_n = slp_n;
    assign sample_out           = smp;
    assign sample_valid_out     = sv;
endmodule // adc_capture

// *** adc_link_asserts.sv ***
// Pin checks between the converter end and the capture end.
// Assumes the testbench wires it to the link interface signals.
`timescale 1ns/1ps

module adc_link_asserts
    import adc_link_pkg::*;
(
    input wire logic                            core_clk_in,
    input wire logic                            rst_n_in,
    input wire logic                            output_enable_n,
    input wire logic [CHANNELS-1:0]             channel_sleep_n,
    input wire logic [CHANNELS-1:0][CODE_W-1:0] data_out,
    input wire logic                            data_oe
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [CHANNELS-1:0] h1, h2, h3, h4;
    logic                bad;

    // Five low samples outlast the two sync flops and the output stage
    always_ff @(posedge core_clk_in) begin
        h1 <= channel_sleep_n;
        h2 <= h1;
        h3 <= h2;
        h4 <= h3;
    end
    always_comb begin
        bad = 1'b0;
        for (int c = 0; c < CHANNELS; c++) begin
            if (!(h1[c] | h2[c] | h3[c] | h4[c] | channel_sleep_n[c])
                && data_out[c] != 10'h000) begin
                bad = 1'b1;
            end
        end
    end

    property p_oe_on;
        (!output_enable_n)[*5] |-> data_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus not driven");
    property p_oe_off;
        output_enable_n[*5] |-> !data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus not floated");
    property p_oe_rise;
        $rose(data_oe) |-> !$past(output_enable_n, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive uncaused");
    property p_oe_fall;
        $fell(data_oe) |-> $past(output_enable_n, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("float uncaused");
    property p_sleep_zero;
        !bad;
    endproperty
    a_sleep_zero: assert property (p_sleep_zero) else $error("sleep code");
    property p_wake_hold;
        $rose(channel_sleep_n[3]) |=> data_out[3] == 10'h000;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("stale code");
endmodule // adc_link_asserts

// *** tb.sv ***
// Testbench: both ends joined by the link; code table, then awkward cases.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
`include "adc_link_defines.svh"

module tb
    import adc_link_pkg::*;
;
    logic                            clk = 1'b0;
    logic                            rst_n = 1'b0;
    logic                            fix_req = 1'b0;
    logic                            read_req = 1'b0;
    logic [CHANNELS-1:0]             on = 8'h00;
    logic [CHANNELS-1:0][CODE_W-1:0] pos = '0;
    logic [CHANNELS-1:0][CODE_W-1:0] neg = '0;
    logic [CHANNELS-1:0][CODE_W-1:0] so;
    logic                            fixed;
    logic [CHANNELS-1:0]             valid;
    logic [CHANNELS-1:0]             svalid;
    int                              fail_count = 0;
    int                              total_checks = 0;
    int                              cyc = 0;
    int                              n;
    code_type rp [5] = '{10'h3ff, 10'h000, 10'h200, 10'h300, 10'h100};
    code_type rn [5] = '{10'h000, 10'h3ff, 10'h200, 10'h100, 10'h300};
    code_type re [5] = '{10'h3ff, 10'h000, 10'h200, 10'h300, 10'h100};

    always #2.5 clk = ~clk;

    adc_link_if link ();
    // Floating bus shows a toggling pattern, never the last code
    assign link.data_in = link.data_oe ? link.data_out
                                       : {40{cyc[0], ~cyc[0]}};

    adc_converter adc_converter_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .link(link), .positive_input_in(pos), .negative_input_in(neg),
        .duty_fixed_out(fixed), .channel_valid_out(valid));
    adc_capture adc_capture_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .link(link), .duty_fix_req_in(fix_req), .read_req_in(read_req),
        .channel_on_in(on), .sample_out(so), .sample_valid_out(svalid));
    adc_link_asserts adc_link_asserts_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .output_enable_n(link.output_enable_n),
        .channel_sleep_n(link.channel_sleep_n),
        .data_out(link.data_out), .data_oe(link.data_oe));

    task automatic check(string what, logic [79:0] seen, logic [79:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Counts edges from the channel_on_in change until every channel in m is valid
    task automatic wake(logic [CHANNELS-1:0] m);
        @(posedge clk);
        on <= m;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (valid !== m && n < 20);
    endtask

    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        check("oe_rst", link.data_oe, 1'h0);
        check("valid_rst", valid, 8'h00);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            fix_req <= m[0];
            tick(5);
            check("duty_sel", link.duty_fix_select, m[0]);
            check("duty_fixed", fixed, m[0]);
        end
        @(posedge clk);
        read_req <= 1'b1;
        wake(8'hff);
        // Capture flop and two sync flops stand ahead of the wake count
        check("wake", n, `WAKE_CYCLES + 3);
        tick(6);
        check("svalid_on", svalid, 8'hff);
        // Each channel gets row (r + c) mod 5, so only channels five apart share a code
        for (int r = 0; r < 5; r++) begin
            @(posedge clk);
            for (int c = 0; c < CHANNELS; c++) begin
                pos[c] <= rp[(r + c) % 5];
                neg[c] <= rn[(r + c) % 5];
            end
            tick(8);
            for (int c = 0; c < CHANNELS; c++) begin
                check("code", link.data_out[c], re[(r + c) % 5]);
                check("capture", so[c], re[(r + c) % 5]);
            end
            check("oe_on", link.data_oe, 1'h1);
        end
        @(posedge clk);
        on <= 8'hf7;
        tick(5);
        check("sleep_valid", valid, 8'hf7);
        check("sleep_code", link.data_out[3], 10'h000);
        check("awake_code", link.data_out[4], re[3]);
        wake(8'hff);
        check("rewake", n, `WAKE_CYCLES + 3);
        @(posedge clk);
        read_req <= 1'b0;
        tick(8);
        check("oe_off", link.data_oe, 1'h0);
        check("svalid_off", svalid, 8'h00);
        // Re-enable: samples wait until the driven bus has reached us
        @(posedge clk);
        read_req <= 1'b1;
        tick(6);
        check("svalid_settle", svalid, 8'h00);
        tick(1);
        check("svalid_back", svalid, 8'hff);
        check("capture_back", so[0], re[4]);
        @(posedge clk);
        read_req <= 1'b0;
        tick(4);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        check("valid_rerst", valid, 8'h00);
        complete_run();
    end
endmodule // tb
